// ==== core/ftfp_pacer.sv ====
`timescale 1ns/10ps
`default_nettype none

// Word buffer between the host writes and the link
module ftfp_fifo import ftfp_pkg::*; #(
    parameter int unsigned WIDTH = FTFP_WORD_W,
    parameter int unsigned DEPTH = FTFP_FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             clkEn,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             wrValid,
    output var  logic             wrReady,
    output var  logic [WIDTH-1:0] rdData,
    output var  logic             rdValid,
    input  wire logic             rdReady
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0]   CNT_FULL = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0]   CNT_ZERO = '0;
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;

    logic [WIDTH-1:0] mem [DEPTH];     // Storage array
    logic [PTR_W-1:0] wrPtr_q, wrPtr_d; // Write position
    logic [PTR_W-1:0] rdPtr_q, rdPtr_d; // Read position
    logic [PTR_W:0]   count_q, count_d; // Occupancy
    logic             ready_q, ready_d; // Registered not-full
    logic             push;
    logic             pop;

    // Pointer advance with wrap at the depth
    function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(DEPTH - 1)) begin
            return PTR_ZERO;
        end
        return p + PTR_W'(1);
    endfunction

    // Read side falls through: the head word shows while count is nonzero
    assign push    = wrValid && ready_q;
    assign pop     = rdValid && rdReady;
    assign rdValid = (count_q != CNT_ZERO);
    assign rdData  = mem[rdPtr_q];
    assign wrReady = ready_q;

    // Next pointers and occupancy
    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (flush) begin
            // Flush drops everything, including a word offered now
            wrPtr_d = PTR_ZERO;
            rdPtr_d = PTR_ZERO;
            count_d = CNT_ZERO;
        end else begin
            if (push) begin
                wrPtr_d = ptrInc(wrPtr_q);
            end
            if (pop) begin
                rdPtr_d = ptrInc(rdPtr_q);
            end
            if (push && !pop) begin
                count_d = count_q + (PTR_W+1)'(1);
            end else if (pop && !push) begin
                count_d = count_q - (PTR_W+1)'(1);
            end
        end
        // Ready is registered, so it looks one word ahead
        ready_d = (count_d != CNT_FULL);
    end

    // Register pointers; storage has no reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wrPtr_q <= PTR_ZERO;
            rdPtr_q <= PTR_ZERO;
            count_q <= CNT_ZERO;
            ready_q <= 1'b0;
        end else if (clkEn) begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            ready_q <= ready_d;
        end
    end

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (clkEn && push && !flush) begin
            mem[wrPtr_q] <= wrData;
        end
    end
endmodule

// Trigger gating and frame pacing for the transmit link
module ftfp_pacer import ftfp_pkg::*; (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   clkEn,
    input  wire logic                   moduleEnableBit,
    input  wire logic                   softTriggerBit,
    input  wire logic                   bufferResetControl,
    input  wire ftfp_cfg_s              cfg,
    input  wire logic                   extTrigger,
    input  wire logic                   strobeIn,
    input  wire logic                   suspendIn,
    input  wire logic [FTFP_WORD_W-1:0] wrData,
    input  wire logic                   wrValid,
    output var  logic                   wrReady,
    input  wire ftfp_led_s              ledSrc,
    output var  logic [FTFP_WORD_W-1:0] txData,
    output var  logic                   txValid,
    output var  logic                   txFrameEnd,
    output var  logic                   runActive,
    output var  ftfp_led_s              ledOut
);
    // Pacing states
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} ftfp_state_e;

    logic [1:0] trigSync_q, trigSync_d;     // Trigger synchroniser
    logic       trigPrev_q, trigPrev_d;     // Last synced trigger
    logic [1:0] strbSync_q, strbSync_d;     // Strobe synchroniser
    logic       strbPrev_q, strbPrev_d;     // Last synced strobe
    logic [1:0] suspSync_q, suspSync_d;     // Suspend synchroniser
    logic       trigLevel;                  // Synced trigger level
    logic       trigRise;                   // One-cycle trigger edge
    logic       slot;                       // One transfer slot
    logic       suspended;                  // Receiver throttle

    ftfp_state_e           state_q, state_d;     // Pacing state
    logic                  armed_q, armed_d;     // Edge trigger latched
    logic [FTFP_CNT_W-1:0] wordCnt_q, wordCnt_d; // Words in frame
    logic [FTFP_CNT_W-1:0] gapCnt_q, gapCnt_d;   // Idle slots left
    logic [FTFP_CNT_W-1:0] blkCnt_q, blkCnt_d;   // Words in block
    logic [FTFP_WORD_W-1:0] txData_q, txData_d;  // Link data
    logic                  txValid_q, txValid_d; // Word strobe
    logic                  txEnd_q, txEnd_d;     // Last word of frame
    logic                  run_q, run_d;         // Sending allowed
    ftfp_led_s             led_q;                // Indicator flops

    logic                  fifoValid;
    logic [FTFP_WORD_W-1:0] fifoData;
    logic                  fifoPop;
    logic                  oneShot;
    logic                  srcOk;
    logic                  stopAll;
    logic                  lastWord;
    logic                  blockDone;

    // Word buffer in the data path
    ftfp_fifo #(
        .WIDTH (FTFP_WORD_W),
        .DEPTH (FTFP_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .flush   (bufferResetControl),
        .wrData  (wrData),
        .wrValid (wrValid),
        .wrReady (wrReady),
        .rdData  (fifoData),
        .rdValid (fifoValid),
        .rdReady (fifoPop)
    );

    // Synchroniser next values; only stage two is read by logic
    always_comb begin
        trigSync_d = {trigSync_q[0], extTrigger};
        strbSync_d = {strbSync_q[0], strobeIn};
        suspSync_d = {suspSync_q[0], suspendIn};
        trigPrev_d = trigSync_q[1];
        strbPrev_d = strbSync_q[1];
    end

    // Synchroniser registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trigSync_q <= FTFP_SYNC_RST;
            strbSync_q <= FTFP_SYNC_RST;
            suspSync_q <= FTFP_SYNC_RST;
            trigPrev_q <= 1'b0;
            strbPrev_q <= 1'b0;
        end else if (clkEn) begin
            trigSync_q <= trigSync_d;
            strbSync_q <= strbSync_d;
            suspSync_q <= suspSync_d;
            trigPrev_q <= trigPrev_d;
            strbPrev_q <= strbPrev_d;
        end
    end

    // Edge detect compares stage two with its delayed copy, never stage one
    assign trigLevel = trigSync_q[1];
    assign trigRise  = trigSync_q[1] && !trigPrev_q;
    assign suspended = suspSync_q[1];
    // Second generation moves a word on each strobe edge
    assign slot = cfg.gen2Link ? (strbSync_q[1] != strbPrev_q)
                               : (strbSync_q[1] && !strbPrev_q);

    // Both one-shot flavours share the block-end and empty-buffer stops
    assign oneShot = (cfg.opMode == FTFP_MODE_SHOT) || (cfg.opMode == FTFP_MODE_SHOT_RL);
    // Disable or buffer reset kill the run at once
    assign stopAll = !moduleEnableBit || bufferResetControl;

    // Only the chosen source gates; level is refused in one-shot
    always_comb begin
        unique case (cfg.trigSel)
            FTFP_TRIG_SOFT:  srcOk = softTriggerBit;
            FTFP_TRIG_EDGE:  srcOk = armed_q;
            FTFP_TRIG_LEVEL: srcOk = trigLevel && !oneShot;
            default:         srcOk = 1'b0;
        endcase
    end

    // Zero frame size acts as one word per frame
    assign lastWord  = (wordCnt_q + FTFP_CNT_ONE) >= cfg.frameSize;
    // Block end matters only in one-shot modes
    assign blockDone = oneShot && ((blkCnt_q + FTFP_CNT_ONE) >= cfg.blockSize);

    // A word leaves only in a slot, unsuspended, with data present
    assign fifoPop = clkEn && (state_q == ST_SEND) && run_q && slot && !suspended
                     && fifoValid && !stopAll;

    // Edge latch and pacing next state
    always_comb begin
        armed_d   = armed_q;
        state_d   = state_q;
        wordCnt_d = wordCnt_q;
        gapCnt_d  = gapCnt_q;
        blkCnt_d  = blkCnt_q;
        if (stopAll) begin
            // Everything returns to idle, partial frame dropped
            armed_d   = 1'b0;
            state_d   = ST_IDLE;
            wordCnt_d = FTFP_CNT_RST;
            gapCnt_d  = FTFP_CNT_RST;
            blkCnt_d  = FTFP_CNT_RST;
        end else begin
            // A new edge wins over the end of the previous block
            if (fifoPop && blockDone) begin
                armed_d = 1'b0;
            end
            if (oneShot && !fifoValid && (state_q == ST_SEND)) begin
                armed_d = 1'b0;
            end
            if (cfg.trigSel == FTFP_TRIG_EDGE && trigRise) begin
                armed_d = 1'b1;
            end
            unique case (state_q)
                ST_IDLE: begin
                    // Leave idle once enabled
                    state_d = ST_SEND;
                end
                ST_SEND: begin
                    // A stall keeps the word count, so a resumed run finishes the frame
                    if (fifoPop) begin
                        blkCnt_d = blockDone ? FTFP_CNT_RST : blkCnt_q + FTFP_CNT_ONE;
                        if (lastWord) begin
                            wordCnt_d = FTFP_CNT_RST;
                            // Gap only for repeating frames with nonzero pause
                            if (cfg.repeatFrames && cfg.framePause != FTFP_CNT_RST) begin
                                state_d  = ST_GAP;
                                gapCnt_d = cfg.framePause;
                            end
                        end else begin
                            wordCnt_d = wordCnt_q + FTFP_CNT_ONE;
                        end
                    end
                end
                ST_GAP: begin
                    // Count idle slots; no data driven meanwhile
                    if (slot) begin
                        gapCnt_d = gapCnt_q - FTFP_CNT_ONE;
                        if (gapCnt_q == FTFP_CNT_ONE) begin
                            state_d = ST_SEND;
                        end
                    end
                end
            endcase
        end
    end

    // Pacing registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            armed_q   <= 1'b0;
            state_q   <= ST_IDLE;
            wordCnt_q <= FTFP_CNT_RST;
            gapCnt_q  <= FTFP_CNT_RST;
            blkCnt_q  <= FTFP_CNT_RST;
        end else if (clkEn) begin
            armed_q   <= armed_d;
            state_q   <= state_d;
            wordCnt_q <= wordCnt_d;
            gapCnt_q  <= gapCnt_d;
            blkCnt_q  <= blkCnt_d;
        end
    end

    // Link output next values
    always_comb begin
        run_d     = !stopAll && srcOk;
        txValid_d = fifoPop;
        txEnd_d   = fifoPop && lastWord;
        // Data holds between words; txValid alone marks a new one
        txData_d  = fifoPop ? fifoData : txData_q;
    end

    // Link output registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            run_q     <= 1'b0;
            txValid_q <= 1'b0;
            txEnd_q   <= 1'b0;
            txData_q  <= FTFP_DATA_RST;
        end else if (clkEn) begin
            run_q     <= run_d;
            txValid_q <= txValid_d;
            txEnd_q   <= txEnd_d;
            txData_q  <= txData_d;
        end
    end

    // Indicator flops, same-clock sources
    // One cycle late with no stretching, so very short bursts may not show
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            led_q <= '0;
        end else if (clkEn) begin
            led_q <= ledSrc;
        end
    end

    assign txData     = txData_q;
    assign txValid    = txValid_q;
    assign txFrameEnd = txEnd_q;
    assign runActive  = run_q;
    assign ledOut     = led_q;
endmodule

`default_nettype wire

// ==== core/ftfp_pkg.sv ====
// Function
// - Edge mode starts on rising edge plus data
// - Edge run ends on disable; in one-shot also on empty, done
// - Buffer reset stops transmission at once
// - Level mode sends only while trigger high
// - Low level halts; high resumes next word
// - One-shot modes refuse the level trigger
// - Pacing only in repeating-frame format
// - Idle gap between consecutive frames
// - Frame size counts 32-bit words
// - Pause counts idle strobe slots
// - Second-generation link uses both strobe edges
// - Zero pause means no gap
// - Output stalls while buffer lacks data
// - Suspend from receiver pauses output
// - Three indicator outputs for bus activity
// - Soft trigger bit gates sending
// - Clearing enable ends all transmission
package ftfp_pkg;

    // Data path widths
    localparam int unsigned FTFP_WORD_W     = 32;
    localparam int unsigned FTFP_FIFO_DEPTH = 16;
    localparam int unsigned FTFP_CNT_W      = 16;

    // Reset values
    localparam logic [FTFP_WORD_W-1:0] FTFP_DATA_RST = 32'h0000_0000;
    localparam logic [FTFP_CNT_W-1:0]  FTFP_CNT_RST  = 16'h0000;
    localparam logic [FTFP_CNT_W-1:0]  FTFP_CNT_ONE  = 16'h0001;
    localparam logic [1:0]             FTFP_SYNC_RST = 2'h0;

    // Trigger source selection
    typedef enum logic [1:0] {
        FTFP_TRIG_SOFT  = 2'h0,
        FTFP_TRIG_EDGE  = 2'h1,
        FTFP_TRIG_LEVEL = 2'h2,
        FTFP_TRIG_RSVD  = 2'h3
    } ftfp_trig_e;

    // Operating mode
    typedef enum logic [1:0] {
        FTFP_MODE_CONT    = 2'h0,
        FTFP_MODE_LOOP    = 2'h1,
        FTFP_MODE_SHOT    = 2'h2,
        FTFP_MODE_SHOT_RL = 2'h3
    } ftfp_mode_e;

    // Host configuration bundle
    typedef struct packed {
        ftfp_trig_e            trigSel;      // Trigger source
        ftfp_mode_e            opMode;       // Operating mode
        logic                  repeatFrames; // Repeating-frame format
        logic                  gen2Link;     // Second-generation link format
        logic [FTFP_CNT_W-1:0] frameSize;    // Words per frame
        logic [FTFP_CNT_W-1:0] framePause;   // Idle slots between frames
        logic [FTFP_CNT_W-1:0] blockSize;    // Words per one-shot block
    } ftfp_cfg_s;

    // Indicator outputs
    typedef struct packed {
        logic busBusy;
        logic dmaActive;
        logic irqRequest;
    } ftfp_led_s;

endpackage

// ==== verification/ftfp_pacer_properties.sv ====
`timescale 1ns/10ps
`default_nettype none

// Port-level checks on the pacer
module ftfp_pacer_properties import ftfp_pkg::*; (
    input wire logic      sys_clk,
    input wire logic      srst,
    input wire logic      clkEn,
    input wire logic      moduleEnableBit,
    input wire logic      bufferResetControl,
    input wire ftfp_cfg_s cfg,
    input wire logic      suspendIn,
    input wire ftfp_led_s ledSrc,
    input wire logic      txValid,
    input wire logic      txFrameEnd,
    input wire logic      runActive,
    input wire logic      wrReady,
    input wire ftfp_led_s ledOut
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Reset itself is the cause here, so no disable
    a_rst_quiet: assert property (disable iff (1'h0) srst && clkEn
        |=> !txValid && !runActive && !wrReady) else $error("output live after reset");
    a_led_copy: assert property (clkEn |=> ledOut == $past(ledSrc))
        else $error("indicator not copied");
    a_flush_stop: assert property (bufferResetControl |=> !txValid)
        else $error("word sent during buffer reset");
    a_dis_stop: assert property (!moduleEnableBit |=> !txValid && !runActive)
        else $error("sending while disabled");
    a_word_gated: assert property (txValid |-> $past(runActive))
        else $error("word without active run");
    a_end_word: assert property (txFrameEnd |-> txValid)
        else $error("frame end without word");
    // Smallest gap is one slot of 4 clocks plus one paused slot
    a_gap_hold: assert property (txFrameEnd && cfg.repeatFrames
        && cfg.framePause != 16'h0000 |=> !txValid [*6]) else $error("gap missing");
    a_susp_hold: assert property (suspendIn [*4] |=> !txValid)
        else $error("word sent under suspend");
    a_one_slot: assert property (txValid |=> !txValid [*2])
        else $error("two words in one slot");

    c_frame: cover property (txFrameEnd);
    c_level: cover property (txValid && cfg.trigSel == FTFP_TRIG_LEVEL);
    c_full: cover property (!wrReady ##1 wrReady);
endmodule

`default_nettype wire

// ==== verification/ftfp_pacer_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module ftfp_pacer_tb_top import ftfp_pkg::*;;
    logic                   sys_clk, srst, moduleEnableBit, softTriggerBit;
    logic                   bufferResetControl, extTrigger, strobeIn, suspendIn;
    logic                   wrValid, wrReady, txValid, txFrameEnd, runActive;
    logic                   strbRun, suspReq, feSeen, clkEn;
    ftfp_cfg_s              cfg;
    ftfp_led_s              ledSrc, ledOut;
    logic [FTFP_WORD_W-1:0] wrData, txData, expWord, seqWord;
    int                     mismatches, cmp_count, rxN, cyc, feCyc, gap;

    ftfp_pacer dut_u (.sys_clk, .srst, .clkEn, .moduleEnableBit, .softTriggerBit,
        .bufferResetControl, .cfg, .extTrigger, .strobeIn, .suspendIn, .wrData, .wrValid,
        .wrReady, .ledSrc, .txData, .txValid, .txFrameEnd, .runActive, .ledOut);
    ftfp_rx_model far_u (.strbRun, .suspReq, .strobe(strobeIn), .suspend(suspendIn));

    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Judge words off the launching edge; time the frame gaps
    always @(negedge sys_clk) begin
        cyc++;
        if (txValid === 1'h1) begin
            `CHK(txData, expWord)
            expWord++;
            rxN++;
            if (feSeen) gap = cyc - feCyc;
            feSeen = (txFrameEnd === 1'h1);
            feCyc = cyc;
        end
        if (cyc > 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Hold each word until the buffer shows room
    task automatic push(input int n);
        repeat (n) begin
            wrData = seqWord;
            wrValid = 1'h1;
            while (wrReady !== 1'h1) tick();
            tick();
            seqWord++;
        end
        wrValid = 1'h0;
    endtask

    task automatic waitRx(input int n);
        for (int i = 0; i < 300 && rxN < n; i++) tick();
    endtask

    task automatic pulse();
        extTrigger = 1'h1;
        tick(4);
        extTrigger = 1'h0;
    endtask

    // Flush, reconfigure, re-enable; frames and blocks are 2 words
    task automatic setup(input ftfp_trig_e t, input ftfp_mode_e m, input logic rep = 1'h0,
                         input logic g2 = 1'h0, input logic [15:0] p = 16'h0000);
        moduleEnableBit = 1'h0;
        bufferResetControl = 1'h1;
        softTriggerBit = 1'h0;
        tick();
        bufferResetControl = 1'h0;
        cfg = '{t, m, rep, g2, 16'h0002, p, 16'h0002};
        moduleEnableBit = 1'h1;
        tick(2);
        expWord = seqWord;
        rxN = 0;
        feSeen = 1'h0;
        gap = 0;
    endtask

    task automatic t_led();
        for (int i = 0; i < 8; i++) begin
            ledSrc = ftfp_led_s'(3'(i));
            tick(2);
            `CHK(ledOut, ledSrc)
        end
        // Low enable must freeze the indicator copy
        clkEn = 1'h0;
        ledSrc = '0;
        tick(2);
        `CHK(ledOut, 3'h7)
        clkEn = 1'h1;
        tick(2);
        `CHK(ledOut, ledSrc)
        $display("t_led done");
    endtask

    task automatic t_soft();
        setup(FTFP_TRIG_SOFT, FTFP_MODE_CONT);
        push(2);
        pulse();
        tick(40);
        `CHK(rxN, 0)
        softTriggerBit = 1'h1;
        waitRx(2);
        `CHK(rxN, 2)
        `CHK(runActive, 1'h1)
        softTriggerBit = 1'h0;
        tick(2);
        `CHK(runActive, 1'h0)
        push(2);
        tick(40);
        `CHK(rxN, 2)
        $display("t_soft done");
    endtask

    task automatic t_edge();
        setup(FTFP_TRIG_EDGE, FTFP_MODE_CONT);
        push(2);
        tick(40);
        `CHK(rxN, 0)
        pulse();
        waitRx(2);
        `CHK(rxN, 2)
        moduleEnableBit = 1'h0;
        tick();
        moduleEnableBit = 1'h1;
        push(2);
        tick(40);
        `CHK(rxN, 2)
        pulse();
        waitRx(4);
        `CHK(rxN, 4)
        $display("t_edge done");
    endtask

    task automatic t_level();
        int n;
        setup(FTFP_TRIG_LEVEL, FTFP_MODE_CONT);
        extTrigger = 1'h1;
        push(6);
        waitRx(2);
        extTrigger = 1'h0;
        tick(20);
        n = rxN;
        tick(40);
        `CHK(rxN, n)
        extTrigger = 1'h1;
        waitRx(6);
        `CHK(rxN, 6)
        extTrigger = 1'h0;
        $display("t_level done");
    endtask

    task automatic t_shot();
        setup(FTFP_TRIG_LEVEL, FTFP_MODE_SHOT);
        extTrigger = 1'h1;
        push(4);
        tick(40);
        `CHK(rxN, 0)
        extTrigger = 1'h0;
        cfg.trigSel = FTFP_TRIG_EDGE;
        tick();
        pulse();
        tick(60);
        `CHK(rxN, 2)
        pulse();
        waitRx(4);
        `CHK(rxN, 4)
        $display("t_shot done");
    endtask

    // Fill under suspend until refused, then drain to empty
    task automatic t_susp();
        // Throttle settles through the synchroniser before the run opens
        suspReq = 1'h1;
        setup(FTFP_TRIG_SOFT, FTFP_MODE_CONT);
        softTriggerBit = 1'h1;
        push(16);
        tick();
        `CHK(wrReady, 1'h0)
        `CHK(rxN, 0)
        suspReq = 1'h0;
        waitRx(16);
        `CHK(rxN, 16)
        $display("t_susp done");
    endtask

    task automatic t_flush();
        suspReq = 1'h1;
        setup(FTFP_TRIG_SOFT, FTFP_MODE_CONT);
        softTriggerBit = 1'h1;
        push(6);
        suspReq = 1'h0;
        waitRx(1);
        bufferResetControl = 1'h1;
        expWord = seqWord;
        tick();
        bufferResetControl = 1'h0;
        tick(40);
        `CHK(rxN, 1)
        push(1);
        waitRx(2);
        `CHK(rxN, 2)
        $display("t_flush done");
    endtask

    // Gap is (pause + 1) slots of 8 clocks for repeating frames, else one slot; 4-clock slots on the second-generation link
    task automatic t_gap();
        localparam logic [3:0]  REP = 4'hb;
        localparam logic [3:0]  G2 = 4'h8;
        localparam logic [15:0] PAU [4] = '{16'h0002, 16'h0000, 16'h0003, 16'h0002};
        localparam int          GAPX [4] = '{24, 8, 8, 12};
        for (int i = 0; i < 4; i++) begin
            setup(FTFP_TRIG_EDGE, FTFP_MODE_CONT, REP[i], G2[i], PAU[i]);
            push(4);
            pulse();
            waitRx(4);
            `CHK(gap, GAPX[i])
        end
        $display("t_gap done");
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        srst = 1'h1;
        {moduleEnableBit, softTriggerBit, bufferResetControl, extTrigger} = 4'h0;
        {wrValid, suspReq, feSeen} = 3'h0;
        strbRun = 1'h1;
        clkEn = 1'h1;
        cfg = '0;
        ledSrc = '0;
        wrData = '0;
        seqWord = 32'h0000_1000;
        expWord = seqWord;
        tick(3);
        srst = 1'h0;
        tick(2);
        t_led();
        t_soft();
        t_edge();
        t_level();
        t_shot();
        t_susp();
        t_flush();
        t_gap();
        tally_and_finish();
    end
endmodule

bind ftfp_pacer ftfp_pacer_properties chk_u (.sys_clk, .srst, .clkEn, .moduleEnableBit,
    .bufferResetControl, .cfg, .suspendIn, .ledSrc, .txValid, .txFrameEnd, .runActive,
    .wrReady, .ledOut);

`default_nettype wire

// ==== verification/ftfp_rx_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Far-end receiver: makes the link strobe, throttles on request
module ftfp_rx_model (
    input  wire logic strbRun, // Strobe allowed to run
    input  wire logic suspReq, // Downstream consumer lagging
    output var  logic strobe,  // Link strobe, 800 ns period
    output var  logic suspend  // Throttle back to the sender
);
    // Free-running strobe; odd offset keeps it out of phase
    initial begin
        strobe = 1'h0;
        #137;
        forever begin
            #400;
            strobe = strbRun ? ~strobe : strobe;
        end
    end

    // Raised while the consumer cannot keep up
    assign suspend = suspReq;
endmodule

`default_nettype wire
